// file: design/dcdf_defines.vh
// Constants shared by the deep FIFO design
`ifndef DCDF_DEFINES_VH
`define DCDF_DEFINES_VH
`define DCDF_DATA_W 18
`define DCDF_DEPTH 8192
`define DCDF_ADDR_W 13
`define DCDF_OFS_W 16
`define DCDF_EMPTY_OFS_RST 16'h007F
`define DCDF_FULL_OFS_RST 16'h007F
`define DCDF_STAGE_DEPTH 8
`define DCDF_STAGE_AW 3
`define DCDF_PIN_W 13
`endif

// file: design/dcdf_fifo.v
// Deep first-in first-out buffer with pin-level write/read ports, flags and cascade
`timescale 1ns/1ps
`include "dcdf_defines.vh"

module dcdf_stage_fifo #(
  parameter W = `DCDF_DATA_W,
  parameter DEPTH = `DCDF_STAGE_DEPTH,
  parameter AW = `DCDF_STAGE_AW
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [W-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [W-1:0] out_data_out,
  output wire [AW:0] count_out
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire [AW:0] used;
  wire push;
  wire pop;

  // Extra pointer bit separates full from empty
  assign used = wr_q - rd_q;
  assign in_ready_out = (used != DEPTH[AW:0]);
  assign out_valid_out = (used != {(AW+1){1'b0}});
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_q[rd_q[AW-1:0]];
  assign count_out = used;

  // Pointer and storage update
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q[AW-1:0]] <= in_data_in;
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // dcdf_stage_fifo

module dcdf_fifo #(
  parameter W = `DCDF_DATA_W,
  parameter DEPTH = `DCDF_DEPTH,
  parameter AW = `DCDF_ADDR_W,
  parameter OW = `DCDF_OFS_W,
  parameter SDEPTH = `DCDF_STAGE_DEPTH,
  parameter SAW = `DCDF_STAGE_AW
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire write_clk_in,
  input wire read_clk_in,
  input wire write_enable_n_in,
  input wire read_enable_n_in,
  input wire [W-1:0] data_in_bus_in,
  input wire load_offset_select_n_in,
  input wire first_load_or_retransmit_in,
  input wire write_cascade_in_n_in,
  input wire read_cascade_in_n_in,
  input wire sync_flag_mode_select_in,
  input wire output_enable_n_in,
  input wire reset_n_in,
  input wire depth_cascade_mode_in,
  output wire [W-1:0] data_out_bus_out,
  output wire data_out_bus_oe_n_out,
  output wire empty_flag_n_out,
  output wire full_flag_n_out,
  output wire almost_empty_flag_n_out,
  output wire almost_full_flag_n_out,
  output wire half_full_or_cascade_out_n_out,
  output wire read_cascade_out_n_out
);
  localparam PW = `DCDF_PIN_W;
  // Count width covers both the deepest fill and the widest offset
  localparam CW_FILL = AW + 2;
  localparam CW_OFS = OW + 1;
  localparam CW = (CW_FILL > CW_OFS) ? CW_FILL : CW_OFS;

  // Pin synchroniser stages; stage 1 only feeds stage 2
  reg [PW-1:0] pin1_q;
  reg [PW-1:0] pin2_q;
  reg [PW-1:0] pin3_q;
  reg [W-1:0] din1_q;
  reg [W-1:0] din2_q;
  wire [PW-1:0] pins_raw;

  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW:0] wptr_q;
  reg [AW:0] rptr_q;
  reg [W-1:0] dout_q;
  reg oe_n_q;
  reg empty_n_q;
  reg full_n_q;
  reg ae_n_q;
  reg af_n_q;
  reg hf_n_q;
  reg wxo_n_q;
  reg rxo_n_q;
  reg [OW-1:0] empty_ofs_q;
  reg [OW-1:0] full_ofs_q;
  reg wsel_q;
  reg rsel_q;
  reg casc_q;
  reg wtok_q;
  reg rtok_q;

  wire wclk_s;
  wire rclk_s;
  wire wen_n_s;
  wire ren_n_s;
  wire ld_n_s;
  wire flrt_s;
  wire wxi_n_s;
  wire rxi_n_s;
  wire sync_flag_mode_select_s;
  wire oe_n_s;
  wire rs_n_s;
  wire casc_s;
  wire wedge;
  wire redge;
  wire rt_pulse;
  wire wxi_fall;
  wire rxi_fall;
  wire clr;
  wire wr_ok;
  wire rd_ok;
  wire push;
  wire rd_fire;
  wire drain;
  wire st_ready;
  wire st_valid;
  wire [W-1:0] st_data;
  wire [SAW:0] st_count;
  wire [AW:0] arr_cnt;
  wire [CW-1:0] arr_c;
  wire [CW-1:0] tot_now;
  wire [CW-1:0] tot_next;
  wire [CW-1:0] arr_next;
  wire [CW-1:0] n_ofs;
  wire [CW-1:0] m_lim;
  wire [CW-1:0] half_lim;
  wire [CW-1:0] depth_c;
  wire [CW-1:0] n_full;
  wire empty_n_d;
  wire ae_n_d;
  wire full_n_d;
  wire af_n_d;
  wire hf_n_d;
  wire ae_async_n;
  wire af_async_n;
  wire ofs_wr;
  wire ofs_rd;
  wire [OW-1:0] ofs_sel;

  assign pins_raw = {depth_cascade_mode_in, reset_n_in, output_enable_n_in, sync_flag_mode_select_in,
                     read_cascade_in_n_in, write_cascade_in_n_in, first_load_or_retransmit_in,
                     load_offset_select_n_in, read_enable_n_in, write_enable_n_in, read_clk_in,
                     write_clk_in, 1'b0};

  // Two flops on every pin before any logic looks at it
  always @(posedge ref_clk_in) begin
    pin1_q <= pins_raw;
    pin2_q <= pin1_q;
  end

  // Third flop only remembers the last settled level for edge detection
  always @(posedge ref_clk_in) begin
    pin3_q <= pin2_q;
  end

  // Data bus travels the same two stages so it lines up with the clock pins
  always @(posedge ref_clk_in) begin
    din1_q <= data_in_bus_in;
    din2_q <= din1_q;
  end

  assign {casc_s, rs_n_s, oe_n_s, sync_flag_mode_select_s, rxi_n_s, wxi_n_s, flrt_s, ld_n_s, ren_n_s, wen_n_s, rclk_s, wclk_s} =
         pin2_q[PW-1:1];
  assign wedge = wclk_s & ~pin3_q[1];
  assign redge = rclk_s & ~pin3_q[2];
  assign rt_pulse = flrt_s & ~pin3_q[6] & ~casc_q;
  assign wxi_fall = ~wxi_n_s & pin3_q[7];
  assign rxi_fall = ~rxi_n_s & pin3_q[8];
  assign clr = reset_in | ~rs_n_s;

  // Only the chain member holding the turn may move data
  assign wr_ok = ~casc_q | wtok_q;
  assign rd_ok = ~casc_q | rtok_q;
  assign push = wedge & ~wen_n_s & ld_n_s & full_n_q & wr_ok & st_ready;
  assign rd_fire = redge & ~ren_n_s & ld_n_s & empty_n_q & rd_ok & ~rt_pulse;

  // Counts from pointer difference plus words still staged
  assign arr_cnt = wptr_q - rptr_q;
  assign arr_c = {{(CW-AW-1){1'b0}}, arr_cnt};
  assign tot_now = arr_c + {{(CW-SAW-1){1'b0}}, st_count};
  assign tot_next = tot_now + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, rd_fire};
  assign arr_next = arr_c + {{(CW-1){1'b0}}, drain} - {{(CW-1){1'b0}}, rd_fire};
  assign depth_c = DEPTH[CW-1:0];
  assign half_lim = depth_c >> 1;
  assign n_ofs = {{(CW-OW){1'b0}}, empty_ofs_q};
  assign n_full = {{(CW-OW){1'b0}}, full_ofs_q};
  // An offset at or past the depth asserts almost-full from the next write edge on, or at once in immediate mode
  assign m_lim = (n_full >= depth_c) ? {CW{1'b0}} : depth_c - n_full;
  assign drain = st_valid & (arr_cnt != DEPTH[AW:0]);

  // Next flag levels; each edge-held flag copies its own on its edge
  assign empty_n_d = (arr_next != {CW{1'b0}});
  assign ae_n_d = (arr_next > n_ofs);
  assign full_n_d = (tot_next < depth_c);
  assign af_n_d = (tot_next < m_lim);
  assign hf_n_d = ~(tot_now > half_lim);
  // Immediate almost flags follow the live counts between edges
  assign ae_async_n = (arr_c > n_ofs);
  assign af_async_n = (tot_now < m_lim);

  // Offset register accesses; they bypass the array and its pointers
  assign ofs_wr = wedge & ~wen_n_s & ~ld_n_s;
  assign ofs_rd = redge & ~ren_n_s & ~ld_n_s;
  assign ofs_sel = rsel_q ? full_ofs_q : empty_ofs_q;

  // Staging buffer absorbs writes; its ready gates the write port
  dcdf_stage_fifo #(
    .W(W),
    .DEPTH(SDEPTH),
    .AW(SAW)
  ) u_stage (
    .ref_clk_in(ref_clk_in),
    .reset_in(clr),
    .in_valid_in(push),
    .in_ready_out(st_ready),
    .in_data_in(din2_q),
    .out_valid_out(st_valid),
    .out_ready_in(drain),
    .out_data_out(st_data),
    .count_out(st_count)
  );

  // Array write side and offset loading
  always @(posedge ref_clk_in) begin
    if (clr) begin
      wptr_q <= {(AW+1){1'b0}};
      wsel_q <= 1'b0;
      empty_ofs_q <= `DCDF_EMPTY_OFS_RST;
      full_ofs_q <= `DCDF_FULL_OFS_RST;
    end else begin
      if (drain) begin
        mem_q[wptr_q[AW-1:0]] <= st_data;
        wptr_q <= wptr_q + 1'b1;
      end
      if (ofs_wr) begin
        if (wsel_q) begin
          full_ofs_q <= din2_q[OW-1:0];
        end else begin
          empty_ofs_q <= din2_q[OW-1:0];
        end
        wsel_q <= ~wsel_q;
      end
    end
  end

  // Read side: array data or offset readback into the output register
  always @(posedge ref_clk_in) begin
    if (clr) begin
      rptr_q <= {(AW+1){1'b0}};
      rsel_q <= 1'b0;
      dout_q <= {W{1'b0}};
    end else if (rt_pulse) begin
      rptr_q <= {(AW+1){1'b0}};
    end else if (ofs_rd) begin
      dout_q <= {{(W-OW){1'b0}}, ofs_sel};
      rsel_q <= ~rsel_q;
    end else if (rd_fire) begin
      dout_q <= mem_q[rptr_q[AW-1:0]];
      rptr_q <= rptr_q + 1'b1;
    end
  end

  // Edge-updated flags, with half-full refreshed every cycle; a blocked edge still refreshes its flag
  always @(posedge ref_clk_in) begin
    if (clr) begin
      empty_n_q <= 1'b0;
      full_n_q <= 1'b1;
      ae_n_q <= 1'b0;
      af_n_q <= 1'b1;
      hf_n_q <= 1'b1;
    end else begin
      if (redge) begin
        empty_n_q <= empty_n_d;
        ae_n_q <= ae_n_d;
      end
      if (wedge) begin
        full_n_q <= full_n_d;
        af_n_q <= af_n_d;
      end
      hf_n_q <= hf_n_d;
    end
  end

  // Cascade turns and straps caught while reset is held
  always @(posedge ref_clk_in) begin
    if (clr) begin
      casc_q <= casc_s;
      wtok_q <= ~flrt_s;
      rtok_q <= ~flrt_s;
      wxo_n_q <= 1'b1;
      rxo_n_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      wxo_n_q <= 1'b1;
      rxo_n_q <= 1'b1;
      if (casc_q & push & (tot_next == depth_c)) begin
        wxo_n_q <= 1'b0;
        wtok_q <= 1'b0;
      end else if (casc_q & wxi_fall) begin
        wtok_q <= 1'b1;
      end
      if (casc_q & rd_fire & (arr_next == {CW{1'b0}})) begin
        rxo_n_q <= 1'b0;
        rtok_q <= 1'b0;
      end else if (casc_q & rxi_fall) begin
        rtok_q <= 1'b1;
      end
      oe_n_q <= oe_n_s | (casc_q & ~rtok_q);
    end
  end

  // Output drive; immediate almost flags skip the edge registers
  assign data_out_bus_out = dout_q;
  assign data_out_bus_oe_n_out = oe_n_q;
  assign empty_flag_n_out = empty_n_q;
  assign full_flag_n_out = full_n_q;
  assign almost_empty_flag_n_out = sync_flag_mode_select_s ? ae_async_n : ae_n_q;
  assign almost_full_flag_n_out = sync_flag_mode_select_s ? af_async_n : af_n_q;
  assign half_full_or_cascade_out_n_out = casc_q ? wxo_n_q : hf_n_q;
  assign read_cascade_out_n_out = rxo_n_q;
endmodule // dcdf_fifo

// file: sim/dcdf_fifo_chk.sv
// Pin-level checker for the deep FIFO
`timescale 1ns/1ps
module dcdf_fifo_chk (
  input wire ref_clk_in,
  input wire reset_in,
  input wire write_clk_in,
  input wire read_clk_in,
  input wire reset_n_in,
  input wire output_enable_n_in,
  input wire sync_flag_mode_select_in,
  input wire [17:0] data_out_bus_out,
  input wire data_out_bus_oe_n_out,
  input wire empty_flag_n_out,
  input wire full_flag_n_out,
  input wire almost_empty_flag_n_out,
  input wire almost_full_flag_n_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // Reset check must run while reset is high, so it drops the default disable
  a_reset_gives_empty: assert property (disable iff (1'b0)
    reset_in ##1 reset_in |-> !empty_flag_n_out && full_flag_n_out) else $error("reset not empty");
  // Pin reset also moves flags, hence the guard on its recent history
  a_empty_on_read: assert property ($changed(empty_flag_n_out) && $past(reset_n_in, 4)
    && $past(reset_n_in, 3) |-> $past(read_clk_in, 2)) else $error("empty moved off read edge");
  a_full_on_write: assert property ($changed(full_flag_n_out) && $past(reset_n_in, 4)
    && $past(reset_n_in, 3) |-> $past(write_clk_in, 2)) else $error("full moved off write edge");
  a_data_on_read: assert property ($changed(data_out_bus_out) && $past(reset_n_in, 4)
    && $past(reset_n_in, 3) |-> $past(read_clk_in, 2)) else $error("data moved off read edge");
  // Enable passes two sync flops and one register
  a_oe_off_bus: assert property (output_enable_n_in [*4] |-> data_out_bus_oe_n_out)
    else $error("bus driven while disabled");
  a_oe_on_bus: assert property ((!output_enable_n_in && reset_n_in) [*6] |-> !data_out_bus_oe_n_out)
    else $error("bus idle while enabled");
  // Immediate almost flags may lead an edge-held empty or full flag, so only clocked mode is held to this
  a_empty_implies_ae: assert property (!empty_flag_n_out && !sync_flag_mode_select_in
    && !$past(sync_flag_mode_select_in, 1) && !$past(sync_flag_mode_select_in, 2) |-> !almost_empty_flag_n_out)
    else $error("empty without almost empty");
  a_full_implies_af: assert property (!full_flag_n_out && !sync_flag_mode_select_in
    && !$past(sync_flag_mode_select_in, 1) && !$past(sync_flag_mode_select_in, 2) |-> !almost_full_flag_n_out)
    else $error("full without almost full");
endmodule // dcdf_fifo_chk
bind dcdf_fifo dcdf_fifo_chk chk_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .write_clk_in(write_clk_in),
  .read_clk_in(read_clk_in), .reset_n_in(reset_n_in), .output_enable_n_in(output_enable_n_in),
  .sync_flag_mode_select_in(sync_flag_mode_select_in),
  .data_out_bus_out(data_out_bus_out), .data_out_bus_oe_n_out(data_out_bus_oe_n_out),
  .empty_flag_n_out(empty_flag_n_out), .full_flag_n_out(full_flag_n_out),
  .almost_empty_flag_n_out(almost_empty_flag_n_out), .almost_full_flag_n_out(almost_full_flag_n_out));

// file: sim/dcdf_pin_partner.sv
// Pin-level writer and reader facing both FIFO ports
`timescale 1ns/1ps
module dcdf_pin_partner (
  input wire ref_clk_in,
  input wire [17:0] data_out_bus_in,
  output reg write_clk_out,
  output reg read_clk_out,
  output reg write_enable_n_out,
  output reg read_enable_n_out,
  output reg [17:0] data_in_bus_out,
  output reg load_offset_select_n_out,
  output reg retransmit_out
);
  // Idle pins; strap pin low as the only device
  initial begin
    {write_clk_out, read_clk_out, retransmit_out} = 3'h0;
    {write_enable_n_out, read_enable_n_out, load_offset_select_n_out} = 3'h7;
    data_in_bus_out = 18'h00000;
  end
  // Steps edges, landing just after the last
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk_in);
      #5;
    end
  endtask
  // High clock phase spans 4 cycles and low at least 5, so the pin sync sees each
  task put(input [17:0] d, input en, input ld);
    begin
      data_in_bus_out = d;
      write_enable_n_out = !en;
      load_offset_select_n_out = !ld;
      tick(1);
      write_clk_out = 1'b1;
      tick(4);
      write_clk_out = 1'b0;
      tick(3);
      {write_enable_n_out, load_offset_select_n_out} = 2'h3;
      data_in_bus_out = ~d; // Released bus never shows the stale word
      tick(1);
    end
  endtask
  task get(output [17:0] q, input en, input ld);
    begin
      read_enable_n_out = !en;
      load_offset_select_n_out = !ld;
      tick(1);
      read_clk_out = 1'b1;
      tick(4);
      read_clk_out = 1'b0;
      tick(3);
      q = data_out_bus_in;
      {read_enable_n_out, load_offset_select_n_out} = 2'h3;
      tick(1);
    end
  endtask
  // Both clocks stay still around the pulse
  task rewind;
    begin
      retransmit_out = 1'b1;
      tick(4);
      retransmit_out = 1'b0;
      tick(4);
    end
  endtask
endmodule // dcdf_pin_partner

// file: sim/dcdf_fifo_tb.sv
// Self-checking bench for the deep FIFO
`timescale 1ns/1ps
module dcdf_fifo_tb;
  localparam int DEPTH = 16;
  reg ref_clk_in, reset_in, reset_n_in, output_enable_n_in, sync_flag_mode_select;
  wire wclk, rclk, wen_n, ren_n, ld_n, rt, oe_n, ef_n, ff_n, ae_n, af_n, hf_n, rxo_n;
  wire [17:0] din, dout;
  integer fails, compares, cycles, i;
  reg [17:0] q;
  dcdf_pin_partner p_u (.ref_clk_in(ref_clk_in), .data_out_bus_in(dout), .write_clk_out(wclk),
    .read_clk_out(rclk), .write_enable_n_out(wen_n), .read_enable_n_out(ren_n), .data_in_bus_out(din),
    .load_offset_select_n_out(ld_n), .retransmit_out(rt));
  // Cascade pins held low as a standalone device
  dcdf_fifo #(.DEPTH(DEPTH), .AW(4)) dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .write_clk_in(wclk),
    .read_clk_in(rclk), .write_enable_n_in(wen_n), .read_enable_n_in(ren_n), .data_in_bus_in(din),
    .load_offset_select_n_in(ld_n), .first_load_or_retransmit_in(rt), .write_cascade_in_n_in(1'b0),
    .read_cascade_in_n_in(1'b0), .sync_flag_mode_select_in(sync_flag_mode_select), .output_enable_n_in(output_enable_n_in),
    .reset_n_in(reset_n_in), .depth_cascade_mode_in(1'b0), .data_out_bus_out(dout), .data_out_bus_oe_n_out(oe_n),
    .empty_flag_n_out(ef_n), .full_flag_n_out(ff_n), .almost_empty_flag_n_out(ae_n),
    .almost_full_flag_n_out(af_n), .half_full_or_cascade_out_n_out(hf_n), .read_cascade_out_n_out(rxo_n));
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  task check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task chkf(input string name, input logic seen, input logic exp);
    check(name, {17'h00000, seen}, {17'h00000, exp});
  endtask
  task final_report;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // A few hundred cycles are needed; the ceiling leaves wide margin
  always @(posedge ref_clk_in) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      final_report;
    end
  end
  initial begin
    fails = 0;
    compares = 0;
    cycles = 0;
    {reset_in, reset_n_in, output_enable_n_in} = 3'h6;
    sync_flag_mode_select = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    #5 reset_in = 1'b0;
    p_u.tick(2);
    chkf("empty", ef_n, 1'b0);
    chkf("full", ff_n, 1'b1);
    $display("test reset done");
    p_u.put(18'h00002, 1'b1, 1'b1);
    p_u.put(18'h00003, 1'b1, 1'b1);
    p_u.get(q, 1'b1, 1'b1);
    check("empty offset", q, 18'h00002);
    p_u.get(q, 1'b1, 1'b1);
    check("full offset", q, 18'h00003);
    $display("test offsets done");
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (i == 12) chkf("almost full", af_n, 1'b1);
      p_u.put(18'h2A5A0 + i[17:0], 1'b1, 1'b0);
    end
    chkf("empty before read edge", ef_n, 1'b0);
    chkf("full", ff_n, 1'b0);
    chkf("almost full", af_n, 1'b0);
    chkf("half full", hf_n, 1'b0);
    p_u.put(18'h15555, 1'b1, 1'b0);
    p_u.get(q, 1'b0, 1'b0);
    chkf("empty", ef_n, 1'b1);
    chkf("almost empty", ae_n, 1'b1);
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (i == 13) chkf("almost empty", ae_n, 1'b1);
      p_u.get(q, 1'b1, 1'b0);
      check("read word", q, 18'h2A5A0 + i[17:0]);
    end
    chkf("empty", ef_n, 1'b0);
    chkf("almost empty", ae_n, 1'b0);
    chkf("half full", hf_n, 1'b1);
    p_u.get(q, 1'b1, 1'b0);
    check("held word", q, 18'h2A5AF);
    p_u.put(18'h00000, 1'b0, 1'b0);
    chkf("full", ff_n, 1'b1);
    $display("test fill drain done");
    // Immediate mode lets almost-empty rise on writes alone; clocked mode waits for a read edge
    sync_flag_mode_select = 1'b1;
    p_u.tick(3);
    for (i = 0; i < 3; i = i + 1) p_u.put(18'h00100 + i[17:0], 1'b1, 1'b0);
    chkf("almost empty immediate", ae_n, 1'b1);
    chkf("empty held to read edge", ef_n, 1'b0);
    sync_flag_mode_select = 1'b0;
    p_u.tick(3);
    chkf("almost empty clocked", ae_n, 1'b0);
    $display("test flag modes done");
    p_u.put(18'h0ABCD, 1'b1, 1'b0);
    p_u.get(q, 1'b0, 1'b0);
    reset_n_in = 1'b0;
    p_u.tick(4);
    reset_n_in = 1'b1;
    p_u.tick(4);
    chkf("empty after pin reset", ef_n, 1'b0);
    for (i = 0; i < 3; i = i + 1) p_u.put(18'h10000 + i[17:0], 1'b1, 1'b0);
    p_u.get(q, 1'b0, 1'b0);
    p_u.get(q, 1'b1, 1'b0);
    p_u.rewind;
    for (i = 0; i < 3; i = i + 1) begin
      p_u.get(q, 1'b1, 1'b0);
      check("replayed word", q, 18'h10000 + i[17:0]);
    end
    $display("test retransmit done");
    output_enable_n_in = 1'b1;
    p_u.tick(5);
    chkf("bus enable", oe_n, 1'b1);
    output_enable_n_in = 1'b0;
    p_u.tick(5);
    chkf("bus enable", oe_n, 1'b0);
    chkf("read cascade idle", rxo_n, 1'b1);
    $display("test output enable done");
    final_report;
  end
endmodule // dcdf_fifo_tb
